// file: src/apds_pkg.sv
// package for the asynchronous parallel display strobe generator
// assumes one display interface clock domain; settings are in clock-fraction units
package apds_pkg;
    localparam int APDS_SET_W = 12;
    localparam int APDS_CNT_W = 13;
    localparam int APDS_WAIT_DLY = 2;
    localparam logic [3:0] APDS_POL_RST = 4'h0;
    localparam logic [APDS_CNT_W-1:0] APDS_CNT_RST = 13'h0000;
    localparam logic [1:0] APDS_KIND_READ = 2'h0;
    localparam logic [1:0] APDS_KIND_ADDR_WR = 2'h1;
    localparam logic [1:0] APDS_KIND_DATA_WR = 2'h2;
    localparam logic [2:0] APDS_ST_IDLE = 3'h1;
    localparam logic [2:0] APDS_ST_ACC = 3'h2;
    localparam logic [2:0] APDS_ST_GAP = 3'h4;
endpackage

// file: src/apds_edge_if.sv
// carries one strobe's half-clock assert/release points to its edge unit
// assumes counts in half clock periods from the access start
`timescale 1ns/1ps
`default_nettype none
interface apds_edge_if;
    logic [12:0] up_half;
    logic [12:0] down_half;
    modport src (output up_half, output down_half);
    modport dst (input up_half, input down_half);
endinterface
`default_nettype wire

// file: src/apds_strobe.sv
// one strobe: active-high level from half-clock up/down points
// assumes i_half counts half clocks within the access
`timescale 1ns/1ps
`default_nettype none
module apds_strobe
    import apds_pkg::*;
(
    input wire logic i_clk_sys,
    input wire logic i_rst_b,
    input wire logic i_run,
    input wire logic [APDS_CNT_W-1:0] i_half,
    apds_edge_if.dst edge_p,
    output logic o_act_rise,
    output logic o_act_fall
);
    // rise value is the level for the first half of the next clock, fall the second
    wire logic [APDS_CNT_W-1:0] half_lo = i_half;
    wire logic [APDS_CNT_W-1:0] half_hi = i_half + 13'h0001;
    wire logic lvl_lo = i_run && half_lo >= edge_p.up_half
        && half_lo < edge_p.down_half;
    wire logic lvl_hi = i_run && half_hi >= edge_p.up_half
        && half_hi < edge_p.down_half;
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_b) begin
            o_act_rise <= 1'b0;
            o_act_fall <= 1'b0;
        end else begin
            o_act_rise <= lvl_lo;
            o_act_fall <= lvl_hi;
        end
    end
endmodule
`default_nettype wire

// file: src/apds_top.sv
// asynchronous parallel display port strobe timing generator
// assumes settings stay stable during an access; wait comes from a pin
// Notes on behaviour
// - strobes active low by default; each polarity selectable by control bits
// - read access lasts ceil(access setting / clock period) clocks
// - write access lasts ceil(access setting / clock period) clocks likewise
// - address writes and data writes have separate access settings
// - chip select asserts and releases at its programmed times
// - register select switches and releases at its programmed times in address writes
// - read strobe asserts and releases at programmed times in reads
// - write strobe asserts and releases at programmed times in writes
// - strobe edges placed on half-clock grid, ceil(2 x setting / period)
// - read data sampled at point from read command, from access start
// - sample point rounded up to whole clocks
// - single access mode: one idle clock after every access
// - wait seen after two clocks; current access ends, next one held
`timescale 1ns/1ps
`default_nettype none
module apds_top
    import apds_pkg::*;
#(
    parameter int DATA_W = 16
) (
    input wire logic i_clk_sys,
    input wire logic i_rst_b,
    input wire logic i_start,
    input wire logic [1:0] i_kind,
    input wire logic [DATA_W-1:0] i_wr_data,
    input wire logic i_single_mode,
    input wire logic [3:0] i_strobe_polarity_control,
    input wire logic [APDS_SET_W-1:0] i_clock_period_setting,
    input wire logic [APDS_SET_W-1:0] i_access_read,
    input wire logic [APDS_SET_W-1:0] i_access_addr_wr,
    input wire logic [APDS_SET_W-1:0] i_access_data_wr,
    input wire logic [APDS_SET_W-1:0] i_cs_strobe_assert_time,
    input wire logic [APDS_SET_W-1:0] i_cs_strobe_release_time,
    input wire logic [APDS_SET_W-1:0] i_rs_strobe_assert_time,
    input wire logic [APDS_SET_W-1:0] i_rs_strobe_release_time,
    input wire logic [APDS_SET_W-1:0] i_rd_strobe_assert_time,
    input wire logic [APDS_SET_W-1:0] i_rd_strobe_release_time,
    input wire logic [APDS_SET_W-1:0] i_wr_strobe_assert_time,
    input wire logic [APDS_SET_W-1:0] i_wr_strobe_release_time,
    input wire logic [APDS_SET_W-1:0] i_read_sample_point,
    input wire logic i_display_wait_input,
    input wire logic [DATA_W-1:0] i_rd_data,
    output logic o_busy,
    output logic o_cs_rise,
    output logic o_cs_fall,
    output logic o_register_select_rise,
    output logic o_register_select_fall,
    output logic o_rd_rise,
    output logic o_rd_fall,
    output logic o_wr_rise,
    output logic o_wr_fall,
    output logic [DATA_W-1:0] o_wr_data,
    output logic o_data_oe,
    output logic [DATA_W-1:0] o_rd_data,
    output logic o_rd_valid
);
    typedef enum logic [2:0] {
        APDS_IDLE = APDS_ST_IDLE,
        APDS_ACC = APDS_ST_ACC,
        APDS_GAP = APDS_ST_GAP
    } apds_state_e;

    apds_state_e state_reg, state_next;
    logic [APDS_CNT_W-1:0] clk_reg;
    logic [APDS_CNT_W-1:0] len_reg;
    logic [APDS_CNT_W-1:0] samp_reg;
    logic [1:0] kind_reg;
    logic [DATA_W-1:0] wdata_reg;
    logic [DATA_W-1:0] rdata_reg;
    logic rvalid_reg;
    logic oe_d_reg;
    logic wait_s1_reg, wait_s2_reg, wait_d_reg;
    logic cs_h, cs_l, rs_h, rs_l, rd_h, rd_l, wr_h, wr_l;
    logic [DATA_W-1:0] rd_s1_reg, rd_s2_reg;

    // ceiling division; zero period treated as one to avoid divide by zero
    function automatic logic [APDS_CNT_W-1:0] ceil_div(
        input logic [APDS_CNT_W:0] num,
        input logic [APDS_SET_W-1:0] per
    );
        logic [APDS_CNT_W:0] p;
        logic [APDS_CNT_W:0] q;
        p = {{(APDS_CNT_W+1-APDS_SET_W){1'b0}}, per};
        if (p == '0)
            p = 14'h0001;
        q = (num + p - 14'h0001) / p;
        return q[APDS_CNT_W-1:0];
    endfunction

    function automatic logic [APDS_CNT_W-1:0] half_pt(
        input logic [APDS_SET_W-1:0] s,
        input logic [APDS_SET_W-1:0] per
    );
        return ceil_div({1'b0, s, 1'b0}, per);
    endfunction

    wire logic [APDS_SET_W-1:0] acc_sel =
        (i_kind == APDS_KIND_READ) ? i_access_read :
        (i_kind == APDS_KIND_ADDR_WR) ? i_access_addr_wr :
        i_access_data_wr;
    wire logic [APDS_CNT_W-1:0] acc_clks =
        ceil_div({2'h0, acc_sel}, i_clock_period_setting);
    wire logic [APDS_CNT_W-1:0] acc_len =
        (acc_clks == '0) ? 13'h0001 : acc_clks;
    wire logic [APDS_CNT_W-1:0] samp_clks =
        ceil_div({2'h0, i_read_sample_point}, i_clock_period_setting);
    wire logic is_read = (kind_reg == APDS_KIND_READ);
    wire logic acc_run = (state_reg == APDS_ACC);
    wire logic acc_last = acc_run && (clk_reg + 13'h0001 >= len_reg);
    wire logic [APDS_CNT_W-1:0] half_now = {clk_reg[APDS_CNT_W-2:0], 1'b0};
    // wait is seen two clocks late through the synchroniser
    wire logic may_start = i_start && !wait_s2_reg;

    apds_edge_if e_cs ();
    apds_edge_if e_rs ();
    apds_edge_if e_rd ();
    apds_edge_if e_wr ();
    assign e_cs.up_half = half_pt(i_cs_strobe_assert_time,
        i_clock_period_setting);
    assign e_cs.down_half = half_pt(i_cs_strobe_release_time,
        i_clock_period_setting);
    assign e_rs.up_half = half_pt(i_rs_strobe_assert_time,
        i_clock_period_setting);
    assign e_rs.down_half = half_pt(i_rs_strobe_release_time,
        i_clock_period_setting);
    assign e_rd.up_half = half_pt(i_rd_strobe_assert_time,
        i_clock_period_setting);
    assign e_rd.down_half = half_pt(i_rd_strobe_release_time,
        i_clock_period_setting);
    assign e_wr.up_half = half_pt(i_wr_strobe_assert_time,
        i_clock_period_setting);
    assign e_wr.down_half = half_pt(i_wr_strobe_release_time,
        i_clock_period_setting);

    apds_strobe u_cs (.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b),
        .i_run(acc_run), .i_half(half_now), .edge_p(e_cs),
        .o_act_rise(cs_h), .o_act_fall(cs_l));
    // register select only steered during address writes
    apds_strobe u_rs (.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b),
        .i_run(acc_run && kind_reg == APDS_KIND_ADDR_WR), .i_half(half_now),
        .edge_p(e_rs), .o_act_rise(rs_h), .o_act_fall(rs_l));
    apds_strobe u_rd (.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b),
        .i_run(acc_run && is_read), .i_half(half_now), .edge_p(e_rd),
        .o_act_rise(rd_h), .o_act_fall(rd_l));
    apds_strobe u_wr (.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b),
        .i_run(acc_run && !is_read), .i_half(half_now), .edge_p(e_wr),
        .o_act_rise(wr_h), .o_act_fall(wr_l));

    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            APDS_IDLE: begin
                if (may_start)
                    state_next = APDS_ACC;
            end
            APDS_ACC: begin
                // current access always completes even under wait
                if (acc_last)
                    state_next = i_single_mode ? APDS_GAP : APDS_IDLE;
            end
            APDS_GAP: begin
                state_next = APDS_IDLE;
            end
            default: state_next = APDS_IDLE;
        endcase
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_b) begin
            state_reg <= APDS_IDLE;
            clk_reg <= APDS_CNT_RST;
            len_reg <= APDS_CNT_RST;
            samp_reg <= APDS_CNT_RST;
            kind_reg <= APDS_KIND_READ;
            wdata_reg <= '0;
        end else begin
            state_reg <= state_next;
            if (state_reg == APDS_IDLE && may_start) begin
                clk_reg <= APDS_CNT_RST;
                len_reg <= acc_len;
                samp_reg <= samp_clks;
                kind_reg <= i_kind;
                wdata_reg <= i_wr_data;
            end else if (acc_run) begin
                clk_reg <= clk_reg + 13'h0001;
            end
        end
    end

    // wait and read bus come from pins: two flops each before use
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_b) begin
            wait_s1_reg <= 1'b0;
            wait_s2_reg <= 1'b0;
            wait_d_reg <= 1'b0;
            rd_s1_reg <= '0;
            rd_s2_reg <= '0;
        end else begin
            wait_s1_reg <= i_display_wait_input;
            wait_s2_reg <= wait_s1_reg;
            wait_d_reg <= wait_s2_reg;
            rd_s1_reg <= i_rd_data;
            rd_s2_reg <= rd_s1_reg;
        end
    end

    // sample point lags the pins by the synchroniser; part of loop-back delay
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_b) begin
            rdata_reg <= '0;
            rvalid_reg <= 1'b0;
        end else begin
            rvalid_reg <= 1'b0;
            if (acc_run && is_read && clk_reg == samp_reg) begin
                rdata_reg <= rd_s2_reg;
                rvalid_reg <= 1'b1;
            end
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_b) begin
            o_cs_rise <= 1'b1;
            o_cs_fall <= 1'b1;
            o_register_select_rise <= 1'b1;
            o_register_select_fall <= 1'b1;
            o_rd_rise <= 1'b1;
            o_rd_fall <= 1'b1;
            o_wr_rise <= 1'b1;
            o_wr_fall <= 1'b1;
            o_busy <= 1'b0;
            o_wr_data <= '0;
            o_data_oe <= 1'b0;
            oe_d_reg <= 1'b0;
            o_rd_data <= '0;
            o_rd_valid <= 1'b0;
        end else begin
            // polarity bit 1 makes that strobe active high
            o_cs_rise <= cs_h ^ ~i_strobe_polarity_control[0];
            o_cs_fall <= cs_l ^ ~i_strobe_polarity_control[0];
            o_register_select_rise <= rs_h ^ ~i_strobe_polarity_control[1];
            o_register_select_fall <= rs_l ^ ~i_strobe_polarity_control[1];
            o_rd_rise <= rd_h ^ ~i_strobe_polarity_control[2];
            o_rd_fall <= rd_l ^ ~i_strobe_polarity_control[2];
            o_wr_rise <= wr_h ^ ~i_strobe_polarity_control[3];
            o_wr_fall <= wr_l ^ ~i_strobe_polarity_control[3];
            o_busy <= (state_reg != APDS_IDLE) || wait_d_reg;
            o_wr_data <= wdata_reg;
            // extra stage keeps the bus driven as long as the write strobe
            oe_d_reg <= acc_run && !is_read;
            o_data_oe <= oe_d_reg;
            o_rd_data <= rdata_reg;
            o_rd_valid <= rvalid_reg;
        end
    end
endmodule
`default_nettype wire

// file: testbench/apds_top_assertions.sv
// port checker for the display strobe timing block
// assumes bound to apds_top; one clock, sync reset
`timescale 1ns/1ps
`default_nettype none
module apds_top_assertions (
    input wire logic i_clk_sys,
    input wire logic i_rst_b,
    input wire logic i_start,
    input wire logic [3:0] i_strobe_polarity_control,
    input wire logic i_display_wait_input,
    input wire logic o_busy,
    input wire logic o_cs_rise,
    input wire logic o_rd_rise,
    input wire logic o_wr_rise,
    input wire logic o_rd_valid
);
    logic [3:0] pol_d1_reg, pol_d2_reg;
    logic calm, cs_on, rd_on, wr_on;
    // pins lag a polarity change, so judge only settled polarity
    assign calm = i_strobe_polarity_control == pol_d1_reg
        && pol_d1_reg == pol_d2_reg;
    assign cs_on = o_cs_rise == i_strobe_polarity_control[0];
    assign rd_on = o_rd_rise == i_strobe_polarity_control[2];
    assign wr_on = o_wr_rise == i_strobe_polarity_control[3];
    always_ff @(posedge i_clk_sys) begin
        pol_d1_reg <= i_strobe_polarity_control;
        pol_d2_reg <= pol_d1_reg;
    end
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_b);
    reset_idle_a: assert property (disable iff (1'b0)
        !i_rst_b |=> !o_busy && !o_rd_valid && o_cs_rise && o_wr_rise)
        else $error("outputs not idle after reset");
    idle_quiet_a: assert property (calm && !o_busy && !$past(o_busy)
        |-> !cs_on && !rd_on && !wr_on) else $error("strobe while idle");
    start_busy_a: assert property (i_start && !o_busy |-> ##2 o_busy)
        else $error("start not taken");
    // sync, hold stage and output flop: busy shows on the fifth sample
    wait_hold_a: assert property (i_display_wait_input [*5] |-> o_busy)
        else $error("wait not held");
    valid_once_a: assert property (o_rd_valid |=> !o_rd_valid)
        else $error("read valid too long");
    // strobe pins trail busy by one clock at access start, and at its end unless single mode or wait extends busy
    cs_busy_a: assert property (calm && cs_on |-> $past(o_busy))
        else $error("chip select outside access");
    rd_busy_a: assert property (calm && rd_on |-> $past(o_busy))
        else $error("read strobe outside access");
    rd_wr_excl_a: assert property (calm |-> !(rd_on && wr_on))
        else $error("read and write strobes together");
    cover property (o_rd_valid);
    cover property (calm && wr_on);
    cover property (i_display_wait_input [*4] ##1 i_start);
endmodule
bind apds_top apds_top_assertions u_chk (.i_clk_sys(i_clk_sys),
    .i_rst_b(i_rst_b), .i_start(i_start), .o_busy(o_busy),
    .i_strobe_polarity_control(i_strobe_polarity_control),
    .i_display_wait_input(i_display_wait_input), .o_cs_rise(o_cs_rise),
    .o_rd_rise(o_rd_rise), .o_wr_rise(o_wr_rise), .o_rd_valid(o_rd_valid));
`default_nettype wire

// file: testbench/apds_panel_model.sv
// display panel answering reads on the parallel data bus
// assumes the read strobe pin and its polarity bit as inputs
`timescale 1ns/1ps
`default_nettype none
module apds_panel_model #(
    parameter int DATA_W = 16
) (
    input wire logic i_clk_sys,
    input wire logic i_rd_pin,
    input wire logic i_rd_pol,
    input wire logic [DATA_W-1:0] i_word,
    output logic [DATA_W-1:0] o_rd_data
);
    initial o_rd_data = '0;
    // released bus shows the inverse so a late sample is caught
    always @(posedge i_clk_sys) begin
        if (i_rd_pin == i_rd_pol) begin
            o_rd_data <= i_word;
        end else begin
            o_rd_data <= ~i_word;
        end
    end
endmodule
`default_nettype wire

// file: testbench/apds_top_test.sv
// self-checking bench for the display strobe timing block
// assumes settings held from start until the access is over
`timescale 1ns/1ps
`default_nettype none
module apds_top_test;
    import apds_pkg::*;
    typedef struct {int len; int vo; logic [15:0] d; logic [15:0] w;
        bit wr; bit sg; logic [3:0][63:0] v;} apds_note_s;
    logic i_clk_sys = 0, i_rst_b = 0, i_start = 0, single = 0, wt = 0;
    logic [1:0] kind = 0;
    logic [3:0] pol = 0;
    logic [15:0] wdat = 0, word = 0, rdo, wdo;
    logic [APDS_SET_W-1:0] st [13] = '{default: '0};
    wire [15:0] rdd;
    wire [7:0] pin;
    logic busy, rvld, oe;
    logic [31:0] r = 32'hce49;
    int num_errors = 0, checks = 0, cyc = 0, k = 99;
    apds_note_s q [$];
    apds_note_s cur;
    logic [3:0][63:0] seen;
    always #2.5 i_clk_sys = ~i_clk_sys;
    apds_top #(.DATA_W(16)) u_dut (.i_clk_sys(i_clk_sys),
        .i_rst_b(i_rst_b), .i_start(i_start), .i_kind(kind),
        .i_wr_data(wdat), .i_single_mode(single),
        .i_strobe_polarity_control(pol), .i_clock_period_setting(st[0]),
        .i_access_read(st[1]), .i_access_addr_wr(st[2]),
        .i_access_data_wr(st[3]), .i_cs_strobe_assert_time(st[4]),
        .i_cs_strobe_release_time(st[5]), .i_rs_strobe_assert_time(st[6]),
        .i_rs_strobe_release_time(st[7]), .i_rd_strobe_assert_time(st[8]),
        .i_rd_strobe_release_time(st[9]), .i_wr_strobe_assert_time(st[10]),
        .i_wr_strobe_release_time(st[11]), .i_read_sample_point(st[12]),
        .i_display_wait_input(wt), .i_rd_data(rdd), .o_busy(busy),
        .o_cs_rise(pin[0]), .o_cs_fall(pin[1]),
        .o_register_select_rise(pin[2]), .o_register_select_fall(pin[3]),
        .o_rd_rise(pin[4]), .o_rd_fall(pin[5]), .o_wr_rise(pin[6]),
        .o_wr_fall(pin[7]), .o_wr_data(wdo), .o_data_oe(oe), .o_rd_data(rdo),
        .o_rd_valid(rvld));
    apds_panel_model #(.DATA_W(16)) u_panel (.i_clk_sys(i_clk_sys),
        .i_rd_pin(pin[4]), .i_rd_pol(pol[2]), .i_word(word),
        .o_rd_data(rdd));
    function automatic logic [31:0] lfsr(logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic int cdiv(int a, int b);
        return (a + b - 1) / b;
    endfunction
    function automatic logic [63:0] win(int u, int d, int p, int l);
        logic [63:0] v;
        v = '0;
        for (int h = 0; h < 2 * l; h++) begin
            v[h] = h >= cdiv(2 * u, p) && h < cdiv(2 * d, p);
        end
        return v;
    endfunction
    task automatic chk(string what, logic [63:0] exp, logic [63:0] got);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic end_sim();
        if (num_errors == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic hold(logic b);
        for (int i = 0; i < 40 && busy !== b; i++) @(posedge i_clk_sys);
    endtask
    task automatic run(int kd, logic w);
        apds_note_s nt;
        int p, u, d, ls;
        logic en;
        r = lfsr(r);
        p = r[1:0] == 0 ? 1 : int'(r[1:0]);
        nt.len = kd == 0 ? 8 : 1 + r[4:2];
        ls = nt.len * p;
        // valid is seen three clocks after the counter reaches sample clock 6
        nt.vo = kd == 0 ? 9 : 0;
        nt.d = r[31:16];
        nt.w = r[15:0];
        nt.wr = kd != 0;
        // single mode adds a gap; a synced wait also keeps busy up
        nt.sg = r[13] | (w && nt.len >= 3);
        st[0] <= 12'(r[1:0]); // zero period acts as one
        st[1 + kd] <= 12'(ls - r[6:5] % p);
        st[12] <= 12'(6 * p - r[8:7] % p);
        word <= r[31:16];
        pol <= r[12:9];
        single <= r[13];
        kind <= 2'(kd);
        wdat <= r[15:0];
        for (int j = 0; j < 4; j++) begin
            r = lfsr(r);
            u = (kd == 0 && j == 2) ? 0 : r[7:0] % (ls + 1);
            d = (kd == 0 && j == 2) ? ls : r[15:8] % (ls + 1);
            en = j == 0 || (j == 1 && kd == 1) || (j == 2 && kd == 0)
                || (j == 3 && kd != 0);
            st[4 + 2 * j] <= 12'(u);
            st[5 + 2 * j] <= 12'(d);
            nt.v[j] = en ? win(u, d, p, nt.len) : '0;
        end
        q.push_back(nt);
        i_start <= 1;
        @(posedge i_clk_sys);
        i_start <= 0;
        wt <= w;
        hold(1);
        hold(0);
        repeat (3) @(posedge i_clk_sys);
    endtask
    // capture each strobe as active per half clock, two clocks late
    always @(posedge i_clk_sys) begin
        k++;
        if (i_start && !busy && i_rst_b) begin
            cur = q.pop_front();
            k = 0;
            seen = '0;
        end
        if (k >= 3 && k <= cur.len + 3) begin
            for (int i = 0; i < 4; i++) begin
                seen[i][2 * k - 6] = pin[2 * i] == pol[i];
                seen[i][2 * k - 5] = pin[2 * i + 1] == pol[i];
            end
            chk("data enable", 64'(cur.wr && k < cur.len + 3), 64'(oe));
            if (cur.wr && k < cur.len + 3) begin
                chk("write word", {48'h0, cur.w}, {48'h0, wdo});
            end
        end
        if (k == cur.len + 2) begin
            chk("busy at end", 64'(cur.sg), 64'(busy));
        end
        if (k == cur.len + 3) begin
            for (int i = 0; i < 4; i++) begin
                chk("halves", cur.v[i], seen[i]);
            end
        end
        if (rvld === 1'b1) begin
            chk("read word", {48'h0, cur.d}, {48'h0, rdo});
            chk("read point", 64'(cur.vo), 64'(k));
        end
    end
    always @(posedge i_clk_sys) begin
        cyc++;
        if (cyc == 3000) begin
            num_errors++;
            end_sim();
        end
    end
    initial begin
        repeat (4) @(posedge i_clk_sys);
        i_rst_b <= 1;
        @(posedge i_clk_sys);
        for (int n = 0; n < 12; n++) run(n % 3, 1'b0);
        run(1, 1'b1);
        i_start <= 1;
        @(posedge i_clk_sys);
        i_start <= 0;
        repeat (8) begin
            @(posedge i_clk_sys);
            chk("cs in wait", {63'h0, ~pol[0]}, {63'h0, pin[0]});
        end
        wt <= 0;
        hold(0);
        repeat (3) @(posedge i_clk_sys);
        run(0, 1'b0);
        end_sim();
    end
endmodule
`default_nettype wire
